// *** gpi_pkg.sv ***
// Purpose: constants for the port 0 pin interrupt block
// Assumes: 25 MHz mclk, 32-bit classic Wishbone, byte address = 4 * index
// Notes:   hold periods are counted in 1 ms ticks derived from mclk
package gpi_pkg;
   // --------------------------------------------------------------
   // register indices and address width
   // --------------------------------------------------------------
   localparam logic [7:0] IDX_MASK = 8'hdc;
   localparam logic [7:0] IDX_POL  = 8'hdd;
   localparam logic [7:0] IDX_CTRL = 8'hde;
   localparam logic [7:0] IDX_MODE = 8'hdf;
   localparam logic [7:0] IDX_STS  = 8'hf0;
   localparam logic [7:0] IDX_IEN  = 8'hf1;
   localparam int         ADR_W    = 10;
   // --------------------------------------------------------------
   // reset values and fields
   // --------------------------------------------------------------
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_POL  = 8'hff;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_STS  = 8'h00;
   localparam logic [7:0] RST_IEN  = 8'h00;
   localparam int         CTRL_EN  = 7;
   localparam int         HOLD_LO  = 4;
   localparam int         HOLD_HI  = 6;
   localparam int         LINE_LO  = 0;
   localparam int         LINE_HI  = 3;
   // --------------------------------------------------------------
   // timing
   // --------------------------------------------------------------
   localparam int MCLK_HZ      = 25_000_000;
   localparam int TICK_MS      = 1;
   localparam int TICK_CYCLES  = MCLK_HZ / 1000 * TICK_MS;
   // hold period in ms per select code
   localparam logic [6:0] HOLD_MS [8] = '{7'h02, 7'h05, 7'h0a, 7'h14, 7'h28, 7'h3c, 7'h50, 7'h64};
   // system request line per routing code, zero means none
   localparam logic [4:0] ROUTE_IRQ [16] = '{5'h00, 5'h09, 5'h03, 5'h0a, 5'h04, 5'h05, 5'h07, 5'h06,
                                             5'h01, 5'h0b, 5'h00, 5'h0c, 5'h00, 5'h0e, 5'h00, 5'h0f};
endpackage : gpi_pkg

// *** gpi_port_irq.sv ***
// Purpose: pin level interrupt logic for one 8-pin port, Wishbone slave
// Assumes: pin inputs synchronous to mclk, one bus master
// Notes:   all state lives in one struct registered once per clock
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - per-pin mask, one enables, resets zero
// - mask acts for input and output pins
// - per-pin polarity, one means low active
// - control bit 7 global enable, reset off
// - fire only after level outlasts hold period
// - hold select decodes 2 to 100 ms
// - routing codes 1 to 7 decode, code 0 disables
// - routing codes 8 to 15, three reserved
// - per-pin mode: continuous or once
module gpi_port_irq #(
   parameter int TICK_CYCLES = gpi_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // port pins and requests
   input  wire logic [7:0]  gpio_pin_i,
   output var  logic        irq_o,
   output var  logic [15:0] irq_line_o
);

   typedef struct packed {
      logic [7:0]      mask;
      logic [7:0]      pol;
      logic [7:0]      ctrl;
      logic [7:0]      mode;
      logic [7:0]      sts;
      logic [7:0]      ien;
      logic [7:0][6:0] cnt;
      logic [7:0]      fired;
      logic [14:0]     div;
      logic            ack;
      logic [31:0]     dat;
      logic            irq;
      logic [15:0]     line;
   } gpi_state_s;

   gpi_state_s st_reg;
   gpi_state_s st_next;
   logic [7:0] qual_c;
   logic [7:0] evt_c;
   logic [6:0] lim_c;
   logic       tick_c;
   logic       req_c;
   logic       wr_c;
   logic [7:0] idx_c;
   logic [4:0] rt_c;

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      idx_c   = wb_adr_i[9:2];
      req_c   = wb_cyc_i & wb_stb_i & ~st_reg.ack;
      // write lands at the edge where the master sees ack
      wr_c    = wb_cyc_i & wb_stb_i & st_reg.ack & wb_we_i & wb_sel_i[0];
      // 1 ms enable from the divider
      tick_c  = (st_reg.div == 15'(TICK_CYCLES - 1));
      st_next.div = tick_c ? 15'h0000 : st_reg.div + 15'h0001;
      lim_c   = gpi_pkg::HOLD_MS[st_reg.ctrl[gpi_pkg::HOLD_HI:gpi_pkg::HOLD_LO]];
      evt_c   = 8'h00;
      for (int i = 0; i < 8; i++) begin
         // qualified active level; pin level sensed in either direction
         qual_c[i] = st_reg.ctrl[gpi_pkg::CTRL_EN] & st_reg.mask[i] & (gpio_pin_i[i] ^ st_reg.pol[i]);
         if (!qual_c[i]) begin
            st_next.cnt[i]   = 7'h00;
            st_next.fired[i] = 1'b0;
         end else if (tick_c && (!st_reg.fired[i] || st_reg.mode[i])) begin
            // fire once the level has outlasted the period
            // at-or-above so a shorter period chosen mid-count still fires
            if (st_reg.cnt[i] >= lim_c) begin
               evt_c[i] = 1'b1;
               // continuous rearms, once waits for release
               if (st_reg.mode[i]) begin
                  st_next.cnt[i] = 7'h00;
               end else begin
                  st_next.fired[i] = 1'b1;
               end
            end else begin
               st_next.cnt[i] = st_reg.cnt[i] + 7'h01;
            end
         end
      end
      // bus answer, one cycle after the request
      st_next.ack = req_c;
      st_next.dat = 32'h0000_0000;
      if (req_c && !wb_we_i) begin
         case (idx_c)
            gpi_pkg::IDX_MASK: st_next.dat[7:0] = st_reg.mask;
            gpi_pkg::IDX_POL:  st_next.dat[7:0] = st_reg.pol;
            gpi_pkg::IDX_CTRL: st_next.dat[7:0] = st_reg.ctrl;
            gpi_pkg::IDX_MODE: st_next.dat[7:0] = st_reg.mode;
            gpi_pkg::IDX_STS:  st_next.dat[7:0] = st_reg.sts;
            gpi_pkg::IDX_IEN:  st_next.dat[7:0] = st_reg.ien;
            default:           st_next.dat = 32'h0000_0000;
         endcase
      end
      st_next.sts = st_reg.sts;
      if (wr_c) begin
         case (idx_c)
            gpi_pkg::IDX_MASK: st_next.mask = wb_dat_i[7:0];
            gpi_pkg::IDX_POL:  st_next.pol  = wb_dat_i[7:0];
            gpi_pkg::IDX_CTRL: st_next.ctrl = wb_dat_i[7:0];
            gpi_pkg::IDX_MODE: st_next.mode = wb_dat_i[7:0];
            gpi_pkg::IDX_STS:  st_next.sts  = st_reg.sts & ~wb_dat_i[7:0];
            gpi_pkg::IDX_IEN:  st_next.ien  = wb_dat_i[7:0];
            default:           st_next.ien  = st_reg.ien;
         endcase
      end
      // set beats a same-cycle clear
      st_next.sts = st_next.sts | evt_c;
      st_next.irq = |(st_next.sts & st_next.ien);
      // routing follows the control value being stored
      rt_c = gpi_pkg::ROUTE_IRQ[st_next.ctrl[gpi_pkg::LINE_HI:gpi_pkg::LINE_LO]];
      st_next.line = 16'h0000;
      // reserved or disabled codes drive nothing
      if (st_next.irq && rt_c != 5'h00) begin
         st_next.line[rt_c[3:0]] = 1'b1;
      end
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_reg      <= '0;
         st_reg.mask <= gpi_pkg::RST_MASK;
         st_reg.pol  <= gpi_pkg::RST_POL;
         st_reg.ctrl <= gpi_pkg::RST_CTRL;
         st_reg.mode <= gpi_pkg::RST_MODE;
         st_reg.sts  <= gpi_pkg::RST_STS;
         st_reg.ien  <= gpi_pkg::RST_IEN;
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_ack_o   = st_reg.ack;
   assign wb_dat_o   = st_reg.dat;
   assign irq_o      = st_reg.irq;
   assign irq_line_o = st_reg.line;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_reset_values: assert property (disable iff (1'b0)
      !rst_n |=> (st_reg.mask == 8'h00 && st_reg.pol == 8'hff && st_reg.ctrl == 8'h00))
      else $error("reset values wrong");
   a_enable_gates: assert property (
      !st_reg.ctrl[7] |-> evt_c == 8'h00) else $error("event while disabled");
   a_mask_gates: assert property (
      (evt_c & ~st_reg.mask) == 8'h00) else $error("event on masked pin");
   a_hold_count: assert property (
      evt_c[0] |-> (st_reg.cnt[0] >= lim_c && tick_c && qual_c[0])) else $error("event before hold period");
   a_hold_decode: assert property (
      st_reg.ctrl[6:4] == 3'h7 |-> lim_c == 7'h64) else $error("hold decode wrong");
   a_once_quiet: assert property (
      (st_reg.fired[0] && !st_reg.mode[0]) |-> !evt_c[0]) else $error("once mode refired");
   a_polarity_low: assert property (
      (st_reg.pol[0] && gpio_pin_i[0]) |-> !qual_c[0]) else $error("high pin active at low polarity");
   a_route_irq9: assert property (
      (irq_o && st_reg.ctrl[3:0] == 4'h1) |-> irq_line_o == 16'h0200) else $error("code 1 not on line 9");
   a_route_rsvd: assert property (
      (st_reg.ctrl[3:0] inside {4'h0, 4'ha, 4'hc, 4'he}) |-> irq_line_o == 16'h0000)
      else $error("reserved route drives line");
   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   a_ack_latency: assert property (
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack late");
   a_sticky_set: assert property (
      evt_c[0] |=> st_reg.sts[0]) else $error("status not set");

   // --------------------------------------------------------------
   // routing, hold, qualify, status and bus checks
   // --------------------------------------------------------------
   // one line at most
   a_line_onehot: assert property (
      $onehot0(irq_line_o))
      else $error("more than one request line");

   a_line_needs_irq: assert property (
      (irq_line_o != 16'h0000) |-> irq_o)
      else $error("line high without irq");

   a_route_irq3: assert property (
      (irq_o && st_reg.ctrl[3:0] == 4'h2) |-> irq_line_o == 16'h0008)
      else $error("code 2 not on line 3");

   a_route_irq1: assert property (
      (irq_o && st_reg.ctrl[3:0] == 4'h8) |-> irq_line_o == 16'h0002)
      else $error("code 8 not on line 1");

   a_route_irq15: assert property (
      (irq_o && st_reg.ctrl[3:0] == 4'hf) |-> irq_line_o == 16'h8000)
      else $error("code 15 not on line 15");

   a_hold_short: assert property (
      st_reg.ctrl[6:4] == 3'h0 |-> lim_c == 7'h02)
      else $error("2 ms decode wrong");

   a_hold_mid: assert property (
      st_reg.ctrl[6:4] == 3'h3 |-> lim_c == 7'h14)
      else $error("20 ms decode wrong");

   a_evt_on_tick: assert property (
      (evt_c != 8'h00) |-> tick_c)
      else $error("event between ticks");

   a_tick_pulse: assert property (
      tick_c |=> !tick_c)
      else $error("tick longer than one cycle");

   a_qual_restart: assert property (
      !qual_c[0] |=> st_reg.cnt[0] == 7'h00)
      else $error("count kept after release");

   a_disable_clear: assert property (
      !st_reg.ctrl[gpi_pkg::CTRL_EN] |=> st_reg.cnt == '0)
      else $error("count runs while disabled");

   a_pin_active: assert property (
      (st_reg.ctrl[7] && st_reg.mask[1] && !st_reg.pol[1] && gpio_pin_i[1]) |-> qual_c[1])
      else $error("high pin not active");

   a_rearm: assert property (
      (evt_c[0] && st_reg.mode[0]) |=> st_reg.cnt[0] == 7'h00)
      else $error("continuous mode not rearmed");

   a_once_latch: assert property (
      (evt_c[0] && !st_reg.mode[0]) |=> st_reg.fired[0])
      else $error("once mode not latched");

   a_sts_sticky: assert property (
      (st_reg.sts[7] && !(wr_c && idx_c == gpi_pkg::IDX_STS && wb_dat_i[7])) |=> st_reg.sts[7])
      else $error("status lost without clear");

   a_sts_clear: assert property (
      (wr_c && idx_c == gpi_pkg::IDX_STS && wb_dat_i[0] && !evt_c[0]) |=> !st_reg.sts[0])
      else $error("status not cleared");

   a_set_wins: assert property (
      (evt_c[0] && wr_c && idx_c == gpi_pkg::IDX_STS && wb_dat_i[0]) |=> st_reg.sts[0])
      else $error("clear beat event");

   a_mask_write: assert property (
      (wr_c && idx_c == gpi_pkg::IDX_MASK) |=> st_reg.mask == $past(wb_dat_i[7:0]))
      else $error("mask write lost");

   a_pol_write: assert property (
      (wr_c && idx_c == gpi_pkg::IDX_POL) |=> st_reg.pol == $past(wb_dat_i[7:0]))
      else $error("polarity write lost");

   // read data only with ack
   a_dat_idle: assert property (
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data without ack");

   c_event:     cover property (evt_c != 8'h00);
   c_irq:       cover property ($rose(irq_o));
   c_retrigger: cover property (evt_c[0] && st_reg.mode[0] ##[1:300] evt_c[0]);
   c_line15:    cover property (irq_line_o[15]);

endmodule : gpi_port_irq

`default_nettype wire

// *** gpi_irq_ctrl_model.sv ***
// Purpose: far-side model of the system interrupt controller inputs
// Assumes: request lines are levels, one bit per system request
// Notes:   reports the highest pending line and a clash flag
`timescale 1ns/10ps
`default_nettype none
module gpi_irq_ctrl_model (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // request lines
   input  wire logic [15:0] irq_line,
   output var  logic [4:0]  line_num,
   output var  logic        multi
);
   // --------------------------------------------------------------
   // line capture
   // --------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         line_num <= 5'h00;
         multi    <= 1'b0;
      end else begin
         line_num <= 5'h00;
         for (int i = 0; i < 16; i++) begin
            if (irq_line[i]) begin
               line_num <= 5'(i);
            end
         end
         // a clash means two blocks fight over one controller
         multi <= ($countones(irq_line) > 1);
      end
   end
endmodule : gpi_irq_ctrl_model
`default_nettype wire

// *** tb.sv ***
// Purpose: self-checking bench for the port pin interrupt block
// Assumes: 1 ms tick shortened to 10 cycles
// Notes:   hold windows checked with tick-phase slack
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int TK = 10;
   logic        mclk, rst_n, cyc, stb, we, ack, irq, multi;
   logic [9:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat, rdat;
   logic [15:0] line;
   logic [7:0]  pin, q;
   logic [4:0]  num;
   int          miscompares, check_count, n;
   int          tbl [16] = '{0, 9, 3, 10, 4, 5, 7, 6, 1, 11, 0, 12, 0, 14, 0, 15};
   int          hms [8]  = '{2, 5, 10, 20, 40, 60, 80, 100};
   gpi_port_irq #(.TICK_CYCLES(TK)) u_gpi_port_irq (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .gpio_pin_i(pin), .irq_o(irq), .irq_line_o(line));
   gpi_irq_ctrl_model u_gpi_irq_ctrl_model (.mclk(mclk), .rst_n(rst_n), .irq_line(line),
      .line_num(num), .multi(multi));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int k;
      @(posedge mclk);
      {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'h1};
      adr <= {idx, 2'b00};
      dat <= {24'h000000, d};
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k >= 50) begin
         miscompares++;
      end
      q = rdat[7:0];
      {cyc, stb} <= 2'b00;
   endtask : bus
   task automatic wait_irq();
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (irq !== 1'b1 && n < 1500);
      if (n >= 1500) begin
         miscompares++;
      end
   endtask : wait_irq
   task automatic t_reset();
      bus(0, 8'hdc, 0); chk(q, 8'h00);
      bus(0, 8'hdd, 0); chk(q, 8'hff);
      bus(0, 8'hde, 0); chk(q, 8'h00);
      bus(0, 8'h80, 0); chk(q, 8'h00);
      $display("reset test done");
   endtask : t_reset
   task automatic t_gate();
      bus(1, 8'hde, 8'h81);
      bus(1, 8'hf1, 8'h01);
      bus(1, 8'hdd, 8'h00);
      pin <= 8'h01;
      repeat (60) @(posedge mclk);
      chk(irq, 0);
      bus(1, 8'hdc, 8'h01);
      bus(1, 8'hde, 8'h01);
      repeat (60) @(posedge mclk);
      chk(irq, 0);
      bus(1, 8'hdd, 8'h01);
      pin <= 8'h00;
      bus(1, 8'hde, 8'h81);
      wait_irq();
      chk(irq, 1);
      bus(1, 8'hdd, 8'h00);
      bus(1, 8'hf0, 8'h01);
      $display("gate test done");
   endtask : t_gate
   task automatic t_hold();
      for (int h = 0; h < 8; h++) begin
         bus(1, 8'hde, {1'b1, 3'(h), 4'h1});
         pin <= 8'h01;
         wait_irq();
         chk(n >= hms[h] * TK && n <= hms[h] * TK + TK + 4, 1);
         chk(line, 16'h0200);
         pin <= 8'h00;
         bus(1, 8'hf0, 8'h01);
      end
      $display("hold test done");
   endtask : t_hold
   task automatic t_mode();
      bus(1, 8'hde, 8'h81);
      pin <= 8'h01;
      wait_irq();
      bus(1, 8'hf0, 8'h01);
      repeat (60) @(posedge mclk);
      bus(0, 8'hf0, 0); chk(q, 8'h00);
      bus(1, 8'hdf, 8'h01);
      repeat (60) @(posedge mclk);
      bus(0, 8'hf0, 0); chk(q, 8'h01);
      pin <= 8'h00;
      bus(1, 8'hdf, 8'h00);
      $display("mode test done");
   endtask : t_mode
   task automatic t_route();
      for (int c = 0; c < 16; c++) begin
         bus(1, 8'hde, 8'h80 | 8'(c));
         repeat (3) @(posedge mclk);
         chk(line, tbl[c] == 0 ? 16'h0000 : 16'h0001 << tbl[c]);
         chk({10'h000, num, multi}, {10'h000, 5'(tbl[c]), 1'b0});
      end
      bus(1, 8'hf1, 8'h00);
      @(posedge mclk);
      chk(irq, 0);
      bus(1, 8'hf1, 8'h01);
      bus(1, 8'hf0, 8'h01);
      repeat (2) @(posedge mclk);
      chk(irq, 0);
      chk(line, 16'h0000);
      $display("route test done");
   endtask : t_route
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   initial begin
      {rst_n, cyc, stb, we, sel, adr, dat, pin} = '0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_gate();
      t_hold();
      t_mode();
      t_route();
      close_out();
   end
   initial begin
      #400000;
      miscompares++;
      close_out();
   end
endmodule : tb
`default_nettype wire
